// ### io_map_defs.svh
// Purpose: constants for the connector terminal function map
// Assumes: function codes and defaults are local encodings
// Notes: included by the package and the top module
`ifndef IO_MAP_DEFS_SVH
`define IO_MAP_DEFS_SVH
`define NUM_IN_TERMS 10
`define NUM_OUT_TERMS 6
`define FIRST_GP_PULSE_TERM 4
`define IN_FN_W 4
`define OUT_FN_W 4
`define NUM_IN_FN 16
`define NUM_OUT_FN 16
// input function codes
`define IFN_NONE 4'h0
`define IFN_RETURN_TO_ORIGIN 4'h1
`define IFN_FREE 4'h2
`define IFN_STOP 4'h3
`define IFN_ALARM_CLEAR 4'h4
`define IFN_FORWARD_INCHING 4'h5
`define IFN_REVERSE_INCHING 4'h6
`define IFN_START 4'h7
`define IFN_DATA_SELECT_BIT_0 4'h8
`define IFN_DATA_SELECT_BIT_1 4'h9
`define IFN_DATA_SELECT_BIT_2 4'hA
`define IFN_EXCITATION_REQ 4'hB
`define IFN_PANEL_LOCK 4'hC
// output function codes
`define OFN_NONE 4'h0
`define OFN_HOMING_DONE 4'h1
`define OFN_IN_POSITION 4'h2
`define OFN_PULSE_INPUT_READY 4'h3
`define OFN_READY 4'h4
`define OFN_MOTION 4'h5
`define OFN_ALARM_OUTPUT_NC 4'h6
// output function codes at or above this value are normally closed
`define OFN_FIRST_NC 4'h6
// step pulse modes
`define MODE_TWO_PULSE 1'b0
`define MODE_ONE_PULSE 1'b1
`endif

// ### io_map_pkg.sv
// Purpose: types for the connector terminal function map
// Assumes: io_map_defs.svh holds the numeric constants
// Notes: function codes are carried as packed fields
`include "io_map_defs.svh"
package io_map_pkg;
    typedef logic [`IN_FN_W-1:0] in_fn_t;
    typedef logic [`OUT_FN_W-1:0] out_fn_t;
    typedef logic [`NUM_IN_FN-1:0] in_fn_vec_t;
    typedef logic [`NUM_OUT_FN-1:0] out_fn_vec_t;
    typedef struct packed {
        logic return_to_origin;
        logic free;
        logic stop;
        logic alarm_clear;
        logic forward_inching;
        logic reverse_inching;
        logic start;
        logic data_select_bit_0;
        logic data_select_bit_1;
        logic data_select_bit_2;
        logic excitation_req;
        logic panel_lock;
    } logic_in_t;
    typedef struct packed {
        logic homing_done;
        logic in_position;
        logic pulse_input_ready;
        logic ready;
        logic motion;
        logic alarm;
    } status_t;
    typedef struct packed {
        logic clockwise_step_pulse;
        logic counterclockwise_step_pulse;
        logic single_step_pulse;
        logic rotation_sense;
    } step_t;
    typedef enum logic [1:0] {
        CFG_IDLE = 2'b00,
        CFG_SEED = 2'b01,
        CFG_RUN = 2'b10
    } cfg_state_t;
endpackage : io_map_pkg

// ### io_terminal_map.sv
// Purpose: map logical I/O functions onto connector terminals
// Assumes: terminal levels are conduction, synchronous to REF_CLK
// Notes: function map loaded on config reset or load strobe
//
// Functional notes
// R01: pulse variant: terminals 4-9 take configured functions
// R02: pulse variant: terminals 0-3 carry step pulses only
// R03: default inputs 4-9: origin, free, stop, clear, inching
// R04: function on several terminals is ORed
// R05: unmapped excitation and panel-lock read as active
// R06: excitation/panel-lock on both sources are ANDed
// R07: six outputs driven by configured functions
// R08: default outputs: homing, in-pos, pulse-ready, ready, motion, alarm
// R09: normally-closed signals invert conduction
// R10: two-pulse or pulse-and-direction on the pulse pairs
// R11: A/B feedback pulses driven differentially
// R12: controller variant: all inputs general, own defaults
// R13: excitation follows excitation request
// R14: no-function terminals and unmapped functions other than excitation/panel-lock are inactive
`timescale 1ns/1ps
`include "io_map_defs.svh"
module io_terminal_map (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PULSE_VARIANT,
    input wire logic STEP_MODE,
    input wire logic CFG_DEFAULTS,
    input wire logic CFG_LOAD,
    input wire logic [`NUM_IN_TERMS*`IN_FN_W-1:0] CFG_IN_FN,
    input wire logic [`NUM_OUT_TERMS*`OUT_FN_W-1:0] CFG_OUT_FN,
    input wire logic [`NUM_IN_TERMS-1:0] IN_COND,
    input wire logic [`NUM_IN_TERMS-1:0] IN_NC,
    input wire io_map_pkg::in_fn_vec_t REMOTE_IN,
    input wire io_map_pkg::in_fn_vec_t REMOTE_MAPPED,
    input wire io_map_pkg::status_t STATUS,
    input wire logic FB_A,
    input wire logic FB_B,
    output io_map_pkg::logic_in_t LOGIC_IN,
    output io_map_pkg::step_t STEP,
    output logic EXCITE,
    output logic [`NUM_OUT_TERMS-1:0] OUT_COND,
    output logic FEEDBACK_A_PHASE_OUT_P,
    output logic FEEDBACK_A_PHASE_OUT_N,
    output logic FEEDBACK_B_PHASE_OUT_P,
    output logic FEEDBACK_B_PHASE_OUT_N,
    output logic CFG_READY
);
    import io_map_pkg::*;

    in_fn_t in_fn_q [`NUM_IN_TERMS];
    out_fn_t out_fn_q [`NUM_OUT_TERMS];
    cfg_state_t state_q;
    in_fn_vec_t direct_act;
    in_fn_vec_t direct_mapped;
    out_fn_vec_t out_src;
    in_fn_vec_t fn_act;
    logic [`NUM_IN_TERMS-1:0] term_on;
    logic exc_act;
    logic lock_act;
    logic [`NUM_IN_TERMS-1:0] term_use;
    logic [`FIRST_GP_PULSE_TERM/2-1:0] pair_on;
    logic [`NUM_OUT_TERMS-1:0] out_nc;
    logic [`NUM_OUT_TERMS-1:0] out_known;
    in_fn_vec_t remote_act;
    logic map_live;
    logic_in_t logic_d;
    step_t step_d;

    // default function of each input terminal, by variant
    function automatic in_fn_t in_default(input int idx, input logic pulse_var);
        in_fn_t f;
        f = `IFN_NONE;
        case (idx)
            0: f = pulse_var ? `IFN_NONE : `IFN_START; // R02 R12
            1: f = pulse_var ? `IFN_NONE : `IFN_DATA_SELECT_BIT_0; // R12
            2: f = pulse_var ? `IFN_NONE : `IFN_DATA_SELECT_BIT_1; // R12
            3: f = pulse_var ? `IFN_NONE : `IFN_DATA_SELECT_BIT_2; // R12
            4: f = `IFN_RETURN_TO_ORIGIN; // R03
            5: f = `IFN_FREE; // R03
            6: f = `IFN_STOP; // R03
            7: f = `IFN_ALARM_CLEAR; // R03
            8: f = `IFN_FORWARD_INCHING; // R03
            9: f = `IFN_REVERSE_INCHING; // R03
            default: f = `IFN_NONE;
        endcase
        return f;
    endfunction : in_default

    function automatic out_fn_t out_default(input int idx);
        out_fn_t f;
        f = `OFN_NONE;
        case (idx)
            0: f = `OFN_HOMING_DONE; // R08
            1: f = `OFN_IN_POSITION; // R08
            2: f = `OFN_PULSE_INPUT_READY; // R08
            3: f = `OFN_READY; // R08
            4: f = `OFN_MOTION; // R08
            5: f = `OFN_ALARM_OUTPUT_NC; // R08
            default: f = `OFN_NONE;
        endcase
        return f;
    endfunction : out_default

    // configuration sequencer: idle, seed defaults, run
    // config reset costs one seed cycle with the map offline
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= CFG_IDLE;
        end else begin
            case (state_q)
                CFG_IDLE: state_q <= CFG_SEED;
                CFG_SEED: state_q <= CFG_RUN;
                CFG_RUN: state_q <= CFG_DEFAULTS ? CFG_SEED : CFG_RUN;
                default: state_q <= CFG_IDLE;
            endcase
        end
    end

    assign map_live = (state_q == CFG_RUN);
    assign CFG_READY = map_live;

    genvar gi;
    // per-terminal map: defaults on seed, host fields on load
    generate
        for (gi = 0; gi < `NUM_IN_TERMS; gi++) begin : g_in
            in_fn_t req;
            assign req = CFG_IN_FN[gi*`IN_FN_W +: `IN_FN_W];
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    in_fn_q[gi] <= `IFN_NONE;
                end else if (state_q == CFG_SEED) begin
                    in_fn_q[gi] <= in_default(gi, PULSE_VARIANT); // R03 R12
                end else if (CFG_LOAD && state_q == CFG_RUN) begin
                    // pulse terminals refuse any function
                    if (PULSE_VARIANT && gi < `FIRST_GP_PULSE_TERM) begin
                        in_fn_q[gi] <= `IFN_NONE; // R02
                    end else begin
                        in_fn_q[gi] <= req; // R01
                    end
                end
            end
            // normally-closed terminal is on when not conducting
            assign term_on[gi] = IN_COND[gi] ^ IN_NC[gi]; // R09
            // a stale controller map must not act on step pulses
            assign term_use[gi] = !(PULSE_VARIANT && gi < `FIRST_GP_PULSE_TERM); // R02
        end
        for (gi = 0; gi < `NUM_OUT_TERMS; gi++) begin : g_out
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    out_fn_q[gi] <= `OFN_NONE;
                end else if (state_q == CFG_SEED) begin
                    out_fn_q[gi] <= out_default(gi); // R08
                end else if (CFG_LOAD && state_q == CFG_RUN) begin
                    out_fn_q[gi] <= CFG_OUT_FN[gi*`OUT_FN_W +: `OUT_FN_W]; // R07
                end
            end
            assign out_nc[gi] = (out_fn_q[gi] >= `OFN_FIRST_NC); // R09
            assign out_known[gi] = (out_fn_q[gi] <= `OFN_ALARM_OUTPUT_NC);
            // unknown or unused codes leave the terminal off
            always_ff @(posedge REF_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    OUT_COND[gi] <= 1'b0;
                end else if (out_fn_q[gi] == `OFN_NONE || !out_known[gi]) begin
                    OUT_COND[gi] <= 1'b0;
                end else if (out_nc[gi]) begin
                    OUT_COND[gi] <= !out_src[out_fn_q[gi]]; // R09
                end else begin
                    OUT_COND[gi] <= out_src[out_fn_q[gi]]; // R07
                end
            end
        end

        // pair on when + conducts and - does not
        for (gi = 0; gi < `FIRST_GP_PULSE_TERM / 2; gi++) begin : g_pair
            assign pair_on[gi] = IN_COND[2*gi] & !IN_COND[2*gi+1]; // R10
        end
    endgenerate

    // remote bits count only where mapped
    assign remote_act = REMOTE_IN & REMOTE_MAPPED; // R14

    // OR every terminal in term_use that carries a function
    always_comb begin
        direct_act = '0;
        direct_mapped = '0;
        for (int t = 0; t < `NUM_IN_TERMS; t++) begin
            if (term_use[t] && in_fn_q[t] != `IFN_NONE) begin // R02 R14
                direct_mapped[in_fn_q[t]] = 1'b1;
                direct_act[in_fn_q[t]] = direct_act[in_fn_q[t]] | term_on[t]; // R04
            end
        end
        fn_act = direct_act | remote_act; // R04
        fn_act[`IFN_NONE] = 1'b0; // R14
    end

    // excitation and panel lock: default on, AND across sources
    function automatic logic ded_act(
        input logic dm,
        input logic da,
        input logic rm,
        input logic ra
    );
        logic v;
        v = 1'b1; // R05
        if (dm) begin
            v = v & da; // R06
        end
        if (rm) begin
            v = v & ra; // R06
        end
        return v;
    endfunction : ded_act

    // the excitation request also drives the motor enable
    assign exc_act = ded_act(
        direct_mapped[`IFN_EXCITATION_REQ],
        direct_act[`IFN_EXCITATION_REQ],
        REMOTE_MAPPED[`IFN_EXCITATION_REQ],
        REMOTE_IN[`IFN_EXCITATION_REQ]
    );
    assign lock_act = ded_act(
        direct_mapped[`IFN_PANEL_LOCK],
        direct_act[`IFN_PANEL_LOCK],
        REMOTE_MAPPED[`IFN_PANEL_LOCK],
        REMOTE_IN[`IFN_PANEL_LOCK]
    );

    // status bits indexed by output function code
    always_comb begin
        out_src = '0;
        out_src[`OFN_HOMING_DONE] = STATUS.homing_done;
        out_src[`OFN_IN_POSITION] = STATUS.in_position;
        out_src[`OFN_PULSE_INPUT_READY] = STATUS.pulse_input_ready;
        out_src[`OFN_READY] = STATUS.ready;
        out_src[`OFN_MOTION] = STATUS.motion;
        out_src[`OFN_ALARM_OUTPUT_NC] = STATUS.alarm;
    end

    // logical inputs as seen through the current map
    always_comb begin
        logic_d = '0;
        logic_d.return_to_origin = fn_act[`IFN_RETURN_TO_ORIGIN];
        logic_d.free = fn_act[`IFN_FREE];
        logic_d.stop = fn_act[`IFN_STOP];
        logic_d.alarm_clear = fn_act[`IFN_ALARM_CLEAR];
        logic_d.forward_inching = fn_act[`IFN_FORWARD_INCHING];
        logic_d.reverse_inching = fn_act[`IFN_REVERSE_INCHING];
        logic_d.start = fn_act[`IFN_START];
        logic_d.data_select_bit_0 = fn_act[`IFN_DATA_SELECT_BIT_0];
        logic_d.data_select_bit_1 = fn_act[`IFN_DATA_SELECT_BIT_1];
        logic_d.data_select_bit_2 = fn_act[`IFN_DATA_SELECT_BIT_2];
        logic_d.excitation_req = exc_act; // R05 R06
        logic_d.panel_lock = lock_act; // R05 R06
    end

    // LOGIC_IN and EXCITE held low until the map is live; OUT_COND is not held
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LOGIC_IN <= '0;
            EXCITE <= 1'b0;
        end else if (!map_live) begin
            LOGIC_IN <= '0;
            EXCITE <= 1'b0;
        end else begin
            LOGIC_IN <= logic_d;
            EXCITE <= exc_act; // R13
        end
    end

    // pair 0 is cw or pulse, pair 1 is ccw or rotation sense
    always_comb begin
        step_d = '0;
        if (PULSE_VARIANT && STEP_MODE == `MODE_TWO_PULSE) begin
            step_d.clockwise_step_pulse = pair_on[0]; // R10
            step_d.counterclockwise_step_pulse = pair_on[1]; // R10
        end else if (PULSE_VARIANT) begin
            step_d.single_step_pulse = pair_on[0]; // R10
            step_d.rotation_sense = pair_on[1]; // R10
        end
    end

    // registered one cycle behind the pins
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            STEP <= '0;
        end else begin
            STEP <= step_d;
        end
    end

    // differential copies of the feedback phases
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FEEDBACK_A_PHASE_OUT_P <= 1'b0;
            FEEDBACK_A_PHASE_OUT_N <= 1'b1;
            FEEDBACK_B_PHASE_OUT_P <= 1'b0;
            FEEDBACK_B_PHASE_OUT_N <= 1'b1;
        end else begin
            FEEDBACK_A_PHASE_OUT_P <= FB_A; // R11
            FEEDBACK_A_PHASE_OUT_N <= !FB_A; // R11
            FEEDBACK_B_PHASE_OUT_P <= FB_B; // R11
            FEEDBACK_B_PHASE_OUT_N <= !FB_B; // R11
        end
    end
endmodule : io_terminal_map

// ### io_terminal_map_sva.sv
// Purpose: port-level checks for io_terminal_map
// Assumes: one clock, async active-low reset
// Notes: bound to every io_terminal_map instance
`timescale 1ns/1ps
`include "io_map_defs.svh"
module io_terminal_map_sva (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PULSE_VARIANT,
    input wire logic STEP_MODE,
    input wire logic CFG_DEFAULTS,
    input wire logic [`NUM_IN_TERMS-1:0] IN_COND,
    input wire io_map_pkg::in_fn_vec_t REMOTE_IN,
    input wire io_map_pkg::in_fn_vec_t REMOTE_MAPPED,
    input wire logic FB_A,
    input wire logic FB_B,
    input wire io_map_pkg::logic_in_t LOGIC_IN,
    input wire io_map_pkg::step_t STEP,
    input wire logic EXCITE,
    input wire logic FEEDBACK_A_PHASE_OUT_P,
    input wire logic FEEDBACK_A_PHASE_OUT_N,
    input wire logic FEEDBACK_B_PHASE_OUT_P,
    input wire logic FEEDBACK_B_PHASE_OUT_N,
    input wire logic CFG_READY
);
    import io_map_pkg::*;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESET_N);
    property p_fb_a;
        $past(RESET_N) |-> FEEDBACK_A_PHASE_OUT_P == $past(FB_A)
            && FEEDBACK_A_PHASE_OUT_N == !$past(FB_A);
    endproperty
    a_fb_a: assert property (p_fb_a) else $error("feedback A pair wrong");
    property p_fb_b;
        $past(RESET_N) |-> FEEDBACK_B_PHASE_OUT_P == $past(FB_B)
            && FEEDBACK_B_PHASE_OUT_N == !$past(FB_B);
    endproperty
    a_fb_b: assert property (p_fb_b) else $error("feedback B pair wrong");
    property p_excite;
        CFG_READY && $past(CFG_READY) && $past(CFG_READY, 2) |-> EXCITE == LOGIC_IN.excitation_req;
    endproperty
    a_excite: assert property (p_excite) else $error("excite differs from request");
    property p_exc_remote;
        $past(REMOTE_MAPPED[`IFN_EXCITATION_REQ] && !REMOTE_IN[`IFN_EXCITATION_REQ])
            |-> !EXCITE;
    endproperty
    a_exc_remote: assert property (p_exc_remote) else $error("excite ignores remote");
    property p_cw;
        PULSE_VARIANT && !STEP_MODE && $past(PULSE_VARIANT && !STEP_MODE && CFG_READY)
            |-> STEP.clockwise_step_pulse == $past(IN_COND[0] && !IN_COND[1]);
    endproperty
    a_cw: assert property (p_cw) else $error("cw pulse wrong");
    property p_ccw;
        PULSE_VARIANT && !STEP_MODE && $past(PULSE_VARIANT && !STEP_MODE && CFG_READY)
            |-> STEP.counterclockwise_step_pulse == $past(IN_COND[2] && !IN_COND[3]);
    endproperty
    a_ccw: assert property (p_ccw) else $error("ccw pulse wrong");
    property p_single;
        PULSE_VARIANT && STEP_MODE && $past(PULSE_VARIANT && STEP_MODE && CFG_READY)
            |-> STEP.single_step_pulse == $past(IN_COND[0] && !IN_COND[1]);
    endproperty
    a_single: assert property (p_single) else $error("single pulse wrong");
    property p_dir;
        PULSE_VARIANT && STEP_MODE && $past(PULSE_VARIANT && STEP_MODE && CFG_READY)
            |-> STEP.rotation_sense == $past(IN_COND[2] && !IN_COND[3]);
    endproperty
    a_dir: assert property (p_dir) else $error("rotation sense wrong");
    property p_boot;
        $rose(RESET_N) |-> !CFG_READY ##1 !CFG_READY ##1 CFG_READY;
    endproperty
    a_boot: assert property (p_boot) else $error("map not ready on time");
    property p_dflt;
        CFG_READY && CFG_DEFAULTS |=> !CFG_READY ##1 CFG_READY;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default reload timing wrong");
endmodule : io_terminal_map_sva
bind io_terminal_map io_terminal_map_sva i_io_terminal_map_sva (
    .REF_CLK, .RESET_N, .PULSE_VARIANT, .STEP_MODE, .CFG_DEFAULTS, .IN_COND, .FB_A, .FB_B,
    .REMOTE_IN, .REMOTE_MAPPED,
    .LOGIC_IN, .STEP, .EXCITE, .FEEDBACK_A_PHASE_OUT_P, .FEEDBACK_A_PHASE_OUT_N,
    .FEEDBACK_B_PHASE_OUT_P, .FEEDBACK_B_PHASE_OUT_N, .CFG_READY
);

// ### host_ctrl_model.sv
// Purpose: host controller driving the connector inputs
// Assumes: pulse pairs are line-driver style, + and - opposite
// Notes: terminals 0-3 are plain levels on the controller variant
`timescale 1ns/1ps
`include "io_map_defs.svh"
module host_ctrl_model (
    input wire logic pulse_en,
    input wire logic [`NUM_IN_TERMS-1:0] gp,
    input wire logic step_a,
    input wire logic step_b,
    output logic [`NUM_IN_TERMS-1:0] in_cond
);
    // pair on means + conducts and - does not
    always_comb begin
        in_cond = gp;
        if (pulse_en) begin
            in_cond[3:0] = {!step_b, step_b, !step_a, step_a};
        end
    end
endmodule : host_ctrl_model

// ### io_terminal_map_test.sv
// Purpose: self-checking bench for io_terminal_map
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes: host model drives the terminal levels
`timescale 1ns/1ps
`include "io_map_defs.svh"
module io_terminal_map_test;
    import io_map_pkg::*;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PULSE_VARIANT = 1'b1;
    logic STEP_MODE = 1'b0;
    logic CFG_DEFAULTS = 1'b0;
    logic CFG_LOAD = 1'b0;
    logic [39:0] CFG_IN_FN = 40'h0;
    logic [23:0] CFG_OUT_FN = 24'h0;
    logic [9:0] IN_COND, IN_NC = 10'h0, gp = 10'h0;
    in_fn_vec_t REMOTE_IN = 16'h0, REMOTE_MAPPED = 16'h0;
    status_t STATUS = 6'h00;
    logic FB_A = 1'b0, FB_B = 1'b0, step_a = 1'b0, step_b = 1'b0;
    logic_in_t LOGIC_IN;
    step_t STEP;
    logic EXCITE, CFG_READY;
    logic [5:0] OUT_COND;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    io_terminal_map i_io_terminal_map (
        .REF_CLK, .RESET_N, .PULSE_VARIANT, .STEP_MODE, .CFG_DEFAULTS, .CFG_LOAD, .CFG_IN_FN,
        .CFG_OUT_FN, .IN_COND, .IN_NC, .REMOTE_IN, .REMOTE_MAPPED, .STATUS, .FB_A, .FB_B,
        .LOGIC_IN, .STEP, .EXCITE, .OUT_COND, .FEEDBACK_A_PHASE_OUT_P(),
        .FEEDBACK_A_PHASE_OUT_N(), .FEEDBACK_B_PHASE_OUT_P(), .FEEDBACK_B_PHASE_OUT_N(),
        .CFG_READY
    );
    host_ctrl_model i_host_ctrl_model (
        .pulse_en(PULSE_VARIANT), .gp(gp), .step_a(step_a), .step_b(step_b), .in_cond(IN_COND)
    );
    task automatic wrap_up;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic tick;
        @(posedge REF_CLK);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        while (CFG_READY !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk(CFG_READY, 1'b1);
    endtask : wait_rdy
    // ctl is {step mode, pair 0, pair 1}
    task automatic row(input logic [9:0] g, input logic [15:0] rin, input logic [15:0] rmap,
                       input logic [9:0] nc, input logic [2:0] ctl, input logic [11:0] li,
                       input logic [3:0] st);
        gp = g;
        REMOTE_IN = rin;
        REMOTE_MAPPED = rmap;
        IN_NC = nc;
        {STEP_MODE, step_a, step_b} = ctl;
        tick();
        tick();
        chk(LOGIC_IN, li);
        chk(EXCITE, li[1]);
        chk(STEP, st);
    endtask : row
    initial begin
        forever #20 REF_CLK = ~REF_CLK;
    end
    // phases on the feedback inputs keep changing
    always @(posedge REF_CLK) begin
        cycles++;
        #1;
        FB_A = ~FB_A;
        FB_B = FB_A ^ cycles[1];
        if (cycles == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge REF_CLK);
        #1;
        RESET_N = 1'b1;
        wait_rdy();
        for (int k = 0; k < 6; k++) begin
            row(10'h010 << k, '0, '0, '0, 3'h0, 12'h003 | (12'h800 >> k), 4'h0);
        end
        for (int k = 0; k < 6; k++) begin
            STATUS = 6'h20 >> k;
            tick();
            tick();
            chk(OUT_COND, (k == 5) ? 6'h00 : ((6'h01 << k) | 6'h20));
        end
        CFG_IN_FN = 40'h2C0B330007;
        CFG_OUT_FN = 24'h023456;
        CFG_LOAD = 1'b1;
        STATUS = 6'h00;
        tick();
        CFG_LOAD = 1'b0;
        row('0, '0, '0, '0, 3'h0, 12'h000, 4'h0);
        row(10'h010, '0, '0, '0, 3'h0, 12'h200, 4'h0);
        row(10'h020, '0, '0, '0, 3'h0, 12'h200, 4'h0);
        row('0, 16'h0008, 16'h0008, '0, 3'h0, 12'h200, 4'h0);
        row(10'h140, '0, '0, '0, 3'h0, 12'h003, 4'h0);
        row(10'h140, '0, 16'h0800, '0, 3'h0, 12'h001, 4'h0);
        row(10'h140, 16'h0800, 16'h0800, '0, 3'h0, 12'h003, 4'h0);
        row(10'h080, '0, '0, '0, 3'h0, 12'h000, 4'h0);
        row('0, '0, '0, '0, 3'h2, 12'h000, 4'h8);
        row('0, '0, '0, '0, 3'h1, 12'h000, 4'h4);
        row('0, '0, '0, '0, 3'h7, 12'h000, 4'h3);
        row('0, '0, '0, 10'h200, 3'h0, 12'h400, 4'h0);
        chk(OUT_COND, 6'h01);
        STATUS = 6'h3F;
        tick();
        tick();
        chk(OUT_COND, 6'h1E);
        PULSE_VARIANT = 1'b0;
        CFG_DEFAULTS = 1'b1;
        tick();
        CFG_DEFAULTS = 1'b0;
        wait_rdy();
        for (int k = 0; k < 4; k++) begin
            row(10'h001 << k, '0, '0, '0, 3'h0, 12'h003 | (12'h020 >> k), 4'h0);
        end
        wrap_up();
    end
endmodule : io_terminal_map_test
